// *** design/delay_timer.sv ***
// Counts two-to-the-code delay units and pulses done at the end
`timescale 1ns/1ps
`default_nettype none

`include "ovp_defs.svh"

module delay_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic unit_tick,
  output logic busy,
  output logic done
);

  logic [7:0] cnt_r;
  logic [7:0] target;

  // ========================================================================
  // Multiple of the unit: 1 for code 0 up to 128 for code 7
  assign target = 8'h01 << code;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= 8'h00;
        busy <= 1'b1;
      end else if (busy && unit_tick) begin
        if (cnt_r + 8'h01 == target) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

endmodule : delay_timer

`default_nettype wire

// *** design/lin_compare.sv ***
// Compares two linear-format values, true when a is at or below b
`timescale 1ns/1ps
`default_nettype none

module lin_compare (
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  output logic a_le_b
);

  // ========================================================================
  // Both sides aligned to one fixed point before comparing
  assign a_le_b = (ovp_pkg::lin_to_fixed(a) <= ovp_pkg::lin_to_fixed(b));

endmodule : lin_compare

`default_nettype wire

// *** design/output_overvoltage_protect_cfg.sv ***
// Command registers, input stop, phase spreading, current trim and OV response
//
// What this block does
// RULE1: Once converting, stop when input voltage falls to the stop threshold.
// RULE2: Offset switching phase from the shared sync clock per interleave setup.
// RULE3: Interleave bits 11:8 hold an unsigned 4-bit group identifier, 0 to 15.
// RULE4: Interleave bits 7:4 give unit count in group, sync source included.
// RULE5: Interleave bits 3:0 give position; sync source must be position zero.
// RULE6: All interleaved units must be synchronized before interleaving works.
// RULE7: Add a 16-bit linear amperes offset to output current readings.
// RULE8: Hold OV fault limit, 16-bit unsigned, exponent minus eleven.
// RULE9: Hold OV warning limit, 16-bit unsigned, exponent minus eleven.
// RULE10: Response 00 keeps operating without interruption on an OV fault.
// RULE11: Response 01 runs for the delay, then retries if fault persists.
// RULE12: Response 10 disables output at once, then follows retry setting.
// RULE13: Response 11 holds output off only while the fault is present.
// RULE14: Retry bits 5:3 count restarts; 000 stays off until fault cleared.
// RULE15: Retry value 111 restarts continuously without limit.
// RULE16: Delay bits 2:0 select two to the code units, 1 to 128.
// RULE17: One delay serves continue time and restart spacing; unit is external.
// RULE18: Flag fault above fault limit; flag warning above warn limit only.
`timescale 1ns/1ps
`default_nettype none

`include "ovp_defs.svh"

module output_overvoltage_protect_cfg (
  input wire logic clk,
  input wire logic rst_n,
  // Command access
  input wire logic [7:0] reg_code,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  output logic reg_ack_r,
  output logic reg_nack_r,
  // Measurements and control
  input wire logic run_request,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] iout_raw,
  input wire logic delay_unit_tick,
  input wire logic clear_faults,
  input wire logic sync_edge,
  // Results
  output logic conv_running_r,
  output logic output_enable_r,
  output logic ov_fault_flag_r,
  output logic ov_warn_flag_r,
  output ovp_pkg::fixed_t iout_reading_r,
  output logic phase_start_r,
  output logic [3:0] group_id_r,
  output ovp_pkg::ovp_state_t ovp_state_r
);

  // ========================================================================
  // Command registers
  logic [15:0] input_stop_threshold_r;
  logic [15:0] phase_spread_config_r;
  logic [15:0] current_reading_trim_r;
  logic [15:0] output_high_fault_limit_r;
  logic [7:0] output_high_fault_action_r;
  logic [15:0] output_high_warn_limit_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_stop_threshold_r <= `RST_INPUT_STOP_THRESHOLD;
      phase_spread_config_r <= `RST_PHASE_SPREAD_CONFIG;
      current_reading_trim_r <= `RST_CURRENT_READING_TRIM;
      output_high_fault_limit_r <= `RST_OUTPUT_HIGH_FAULT_LIMIT;
      output_high_fault_action_r <= `RST_OUTPUT_HIGH_FAULT_ACTION;
      output_high_warn_limit_r <= `RST_OUTPUT_HIGH_WARN_LIMIT;
    end else if (reg_wr) begin
      case (reg_code)
        `CODE_INPUT_STOP_THRESHOLD: begin
          input_stop_threshold_r <= reg_wdata; // RULE1
        end
        `CODE_PHASE_SPREAD_CONFIG: begin
          // Bits 15:12 are not stored and read as zero
          phase_spread_config_r <= {4'h0, reg_wdata[11:0]}; // RULE3 RULE4
        end
        `CODE_CURRENT_READING_TRIM: begin
          current_reading_trim_r <= reg_wdata; // RULE7
        end
        `CODE_OUTPUT_HIGH_FAULT_LIMIT: begin
          output_high_fault_limit_r <= reg_wdata; // RULE8
        end
        `CODE_OUTPUT_HIGH_FAULT_ACTION: begin
          output_high_fault_action_r <= reg_wdata[7:0];
        end
        `CODE_OUTPUT_HIGH_WARN_LIMIT: begin
          output_high_warn_limit_r <= reg_wdata; // RULE9
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Command answers, one cycle after the strobe
  logic code_known;

  always_comb begin
    case (reg_code)
      `CODE_INPUT_STOP_THRESHOLD,
      `CODE_PHASE_SPREAD_CONFIG,
      `CODE_CURRENT_READING_TRIM,
      `CODE_OUTPUT_HIGH_FAULT_LIMIT,
      `CODE_OUTPUT_HIGH_FAULT_ACTION,
      `CODE_OUTPUT_HIGH_WARN_LIMIT: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_ack_r <= 1'b0;
      reg_nack_r <= 1'b0;
    end else begin
      reg_ack_r <= (reg_wr || reg_rd) && code_known;
      reg_nack_r <= (reg_wr || reg_rd) && !code_known;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_code)
        `CODE_INPUT_STOP_THRESHOLD: reg_rdata_r <= input_stop_threshold_r;
        `CODE_PHASE_SPREAD_CONFIG: reg_rdata_r <= phase_spread_config_r;
        `CODE_CURRENT_READING_TRIM: reg_rdata_r <= current_reading_trim_r;
        `CODE_OUTPUT_HIGH_FAULT_LIMIT: begin
          reg_rdata_r <= output_high_fault_limit_r;
        end
        `CODE_OUTPUT_HIGH_FAULT_ACTION: begin
          reg_rdata_r <= {8'h00, output_high_fault_action_r};
        end
        `CODE_OUTPUT_HIGH_WARN_LIMIT: reg_rdata_r <= output_high_warn_limit_r;
        default: reg_rdata_r <= 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // Input stop
  logic vin_at_stop;

  lin_compare u_vin_stop (
    .a(vin_meas),
    .b(input_stop_threshold_r),
    .a_le_b(vin_at_stop)
  );

  // Start is gated by run_request and vin above the stop threshold; the start threshold lives elsewhere
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_running_r <= 1'b0;
    end else if (!run_request || (conv_running_r && vin_at_stop)) begin
      conv_running_r <= 1'b0; // RULE1
    end else if (run_request && !vin_at_stop) begin
      conv_running_r <= 1'b1;
    end
  end

  // ========================================================================
  // Current reading trim
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iout_reading_r <= '0;
    end else begin
      iout_reading_r <= ovp_pkg::lin_to_fixed(iout_raw)
        + ovp_pkg::lin_to_fixed(current_reading_trim_r); // RULE7
    end
  end

  // ========================================================================
  // Phase spreading against the sync clock
  logic [15:0] per_cnt_r;
  logic [15:0] period_r;
  logic [1:0] sync_seen_r;
  logic fired_r;
  logic [3:0] rail_count;
  logic [3:0] rail_pos;
  logic [19:0] elapsed_scaled;
  logic [19:0] target_scaled;
  logic phase_due;

  assign rail_count = phase_spread_config_r[`RAIL_COUNT_HI:`RAIL_COUNT_LO];
  assign rail_pos = phase_spread_config_r[`RAIL_POS_HI:`RAIL_POS_LO];
  assign elapsed_scaled = per_cnt_r * rail_count;
  assign target_scaled = period_r * rail_pos;

  // Position zero, or a position outside the group, starts on the sync edge
  always_comb begin
    if (rail_pos == 4'h0 || rail_pos >= rail_count) begin
      phase_due = 1'b1; // RULE5
    end else begin
      phase_due = (elapsed_scaled >= target_scaled); // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_cnt_r <= 16'h0000;
      period_r <= 16'h0000;
      sync_seen_r <= 2'h0;
    end else if (sync_edge) begin
      per_cnt_r <= 16'h0000;
      period_r <= per_cnt_r;
      if (sync_seen_r != 2'h3) begin
        sync_seen_r <= sync_seen_r + 2'h1;
      end
    end else if (per_cnt_r != `SYNC_PERIOD_MAX) begin
      per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  // No phase start until three sync edges have been seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fired_r <= 1'b0;
      phase_start_r <= 1'b0;
    end else begin
      phase_start_r <= 1'b0;
      if (sync_edge) begin
        fired_r <= 1'b0;
      end else if (!fired_r && sync_seen_r == 2'h3 && phase_due) begin
        fired_r <= 1'b1; // RULE6
        phase_start_r <= 1'b1; // RULE2
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      group_id_r <= 4'h0;
    end else begin
      group_id_r <= phase_spread_config_r[`GROUP_ID_HI:`GROUP_ID_LO]; // RULE3
    end
  end

  // ========================================================================
  // Overvoltage detection and sticky flags
  logic ov_now;
  logic warn_now;

  // Same fixed exponent on both sides, so a plain unsigned compare serves
  assign ov_now = (vout_meas > output_high_fault_limit_r); // RULE8 RULE18
  assign warn_now = (vout_meas > output_high_warn_limit_r); // RULE9 RULE18

  // Set wins over clear so a fault in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ov_fault_flag_r <= 1'b0;
      ov_warn_flag_r <= 1'b0;
    end else begin
      ov_fault_flag_r <= ov_now || (ov_fault_flag_r && !clear_faults);
      ov_warn_flag_r <= warn_now || (ov_warn_flag_r && !clear_faults);
    end
  end

  // ========================================================================
  // Fault response
  logic [1:0] resp;
  logic [2:0] retries;
  logic [2:0] delay_code;
  logic [2:0] retry_used_r;
  ovp_pkg::ovp_state_t state_nxt;
  logic timer_start;
  logic retry_take;
  logic retry_clr;
  logic timer_done;

  assign resp = output_high_fault_action_r[`ACTION_RESP_HI:`ACTION_RESP_LO];
  assign retries =
    output_high_fault_action_r[`ACTION_RETRY_HI:`ACTION_RETRY_LO];
  assign delay_code =
    output_high_fault_action_r[`ACTION_DELAY_HI:`ACTION_DELAY_LO];

  // One timer covers both the continue window and the restart spacing
  delay_timer u_delay (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start),
    .code(delay_code), // RULE16
    .unit_tick(delay_unit_tick), // RULE17
    .busy(),
    .done(timer_done)
  );

  always_comb begin
    state_nxt = ovp_state_r;
    timer_start = 1'b0;
    retry_take = 1'b0;
    retry_clr = 1'b0;
    case (ovp_state_r)
      ovp_pkg::ST_RUN: begin
        if (ov_now) begin
          case (resp)
            `RESP_IGNORE: state_nxt = ovp_pkg::ST_RUN; // RULE10
            `RESP_CONTINUE: begin
              state_nxt = ovp_pkg::ST_CONT_DELAY; // RULE11
              timer_start = 1'b1; // RULE17
            end
            `RESP_DISABLE: begin
              state_nxt = ovp_pkg::ST_LATCHED; // RULE12
            end
            default: state_nxt = ovp_pkg::ST_HOLD_OFF; // RULE13
          endcase
        end
      end
      ovp_pkg::ST_CONT_DELAY: begin
        if (timer_done) begin
          state_nxt = ov_now ? ovp_pkg::ST_LATCHED : ovp_pkg::ST_RUN; // RULE11
        end
      end
      ovp_pkg::ST_RETRY_WAIT: begin
        if (timer_done) begin
          state_nxt = ovp_pkg::ST_RUN;
        end
      end
      ovp_pkg::ST_LATCHED: begin
        if (clear_faults) begin
          state_nxt = ovp_pkg::ST_RUN; // RULE14
          retry_clr = 1'b1;
        end
      end
      ovp_pkg::ST_HOLD_OFF: begin
        if (!ov_now) begin
          state_nxt = ovp_pkg::ST_RUN; // RULE13
        end
      end
      default: state_nxt = ovp_pkg::ST_RUN;
    endcase
    // A shutdown becomes a timed restart while restarts remain
    if (state_nxt == ovp_pkg::ST_LATCHED && ovp_state_r != ovp_pkg::ST_LATCHED
        && retries != `RETRY_NONE) begin // RULE14
      if (retries == `RETRY_ENDLESS) begin
        state_nxt = ovp_pkg::ST_RETRY_WAIT; // RULE15
        timer_start = 1'b1;
      end else if (retry_used_r < retries) begin
        state_nxt = ovp_pkg::ST_RETRY_WAIT; // RULE14
        timer_start = 1'b1; // RULE17
        retry_take = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovp_state_r <= ovp_pkg::ST_RUN;
    end else begin
      ovp_state_r <= state_nxt;
    end
  end

  // Restart budget refills only when faults are cleared by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retry_used_r <= 3'h0;
    end else if (retry_clr || clear_faults) begin
      // A restart taken in the clearing cycle still spends its budget
      retry_used_r <= {2'h0, retry_take};
    end else if (retry_take) begin
      retry_used_r <= retry_used_r + 3'h1;
    end
  end

  // ========================================================================
  // Output enable
  logic ovp_allows;

  always_comb begin
    case (ovp_state_r)
      ovp_pkg::ST_RUN: ovp_allows = 1'b1;
      ovp_pkg::ST_CONT_DELAY: ovp_allows = 1'b1; // RULE11
      default: ovp_allows = 1'b0; // RULE12
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_enable_r <= 1'b0;
    end else begin
      output_enable_r <= conv_running_r && ovp_allows;
    end
  end

endmodule : output_overvoltage_protect_cfg

`default_nettype wire

// *** design/ovp_defs.svh ***
// Register codes, field positions, reset values and timing for the OV block
`ifndef OVP_DEFS_SVH
`define OVP_DEFS_SVH

// ==========================================================================
// Command codes
`define CODE_INPUT_STOP_THRESHOLD 8'h36
`define CODE_PHASE_SPREAD_CONFIG 8'h37
`define CODE_CURRENT_READING_TRIM 8'h39
`define CODE_OUTPUT_HIGH_FAULT_LIMIT 8'h40
`define CODE_OUTPUT_HIGH_FAULT_ACTION 8'h41
`define CODE_OUTPUT_HIGH_WARN_LIMIT 8'h42

// ==========================================================================
// Field positions
`define GROUP_ID_HI 11
`define GROUP_ID_LO 8
`define RAIL_COUNT_HI 7
`define RAIL_COUNT_LO 4
`define RAIL_POS_HI 3
`define RAIL_POS_LO 0
`define ACTION_RESP_HI 7
`define ACTION_RESP_LO 6
`define ACTION_RETRY_HI 5
`define ACTION_RETRY_LO 3
`define ACTION_DELAY_HI 2
`define ACTION_DELAY_LO 0

// ==========================================================================
// Field encodings
`define RESP_IGNORE 2'h0
`define RESP_CONTINUE 2'h1
`define RESP_DISABLE 2'h2
`define RESP_HOLD_OFF 2'h3
`define RETRY_NONE 3'h0
`define RETRY_ENDLESS 3'h7

// ==========================================================================
// Reset values
`define RST_INPUT_STOP_THRESHOLD 16'h0000
`define RST_PHASE_SPREAD_CONFIG 16'h0000
`define RST_CURRENT_READING_TRIM 16'h0000
`define RST_OUTPUT_HIGH_FAULT_LIMIT 16'hFFFF
`define RST_OUTPUT_HIGH_FAULT_ACTION 8'h80
`define RST_OUTPUT_HIGH_WARN_LIMIT 16'hFFFF

// ==========================================================================
// Timing
`define DELAY_CODE_MAX_TICKS 8'h80
`define SYNC_PERIOD_MAX 16'hFFFF

`endif

// *** design/ovp_pkg.sv ***
// Types and the linear-format helper shared by the OV block
package ovp_pkg;

  // ========================================================================
  // Types
  typedef logic signed [47:0] fixed_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_CONT_DELAY = 3'b001,
    ST_RETRY_WAIT = 3'b010,
    ST_LATCHED = 3'b011,
    ST_HOLD_OFF = 3'b100
  } ovp_state_t;

  // ========================================================================
  // Linear format to signed fixed point, 16 fractional bits
  function automatic fixed_t lin_to_fixed(input logic [15:0] lin);
    fixed_t m;
    logic [4:0] sh;
    m = {{37{lin[10]}}, lin[10:0]};
    // Exponent plus sixteen: flip the sign bit of the 5-bit field
    sh = {~lin[15], lin[14:11]};
    return m <<< sh;
  endfunction : lin_to_fixed

endpackage : ovp_pkg

// *** sim/far_side_model.sv ***
// Far-side model: sync-source sibling and delay time-unit source
`timescale 1ns/1ps
`default_nettype none

module far_side_model #(
  parameter int SYNC_PERIOD = 20,
  parameter int TICK_PERIOD = 5
) (
  input wire logic clk,
  input wire logic sync_on,
  output logic sync_edge,
  output logic delay_unit_tick
);
  int sync_cnt = 0;
  int tick_cnt = 0;

  initial begin
    sync_edge = 1'b0;
    delay_unit_tick = 1'b0;
  end

  // Sync line stays low unless the sibling is sourcing the clock
  always @(negedge clk) begin
    sync_cnt <= (sync_cnt == SYNC_PERIOD - 1) ? 0 : sync_cnt + 1;
    sync_edge <= sync_on && (sync_cnt == 0);
  end

  // Time unit comes from outside the block, free running
  always @(negedge clk) begin
    tick_cnt <= (tick_cnt == TICK_PERIOD - 1) ? 0 : tick_cnt + 1;
    delay_unit_tick <= (tick_cnt == 0);
  end
endmodule : far_side_model

`default_nettype wire

// *** sim/ovp_checker_assertions.sv ***
// Concurrent checks on the ports of the OV block
`timescale 1ns/1ps
`default_nettype none

`include "ovp_defs.svh"

module ovp_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_code,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] vout_meas,
  input wire logic clear_faults,
  input wire logic [15:0] reg_rdata_r,
  input wire logic reg_ack_r,
  input wire logic reg_nack_r,
  input wire logic output_enable_r,
  input wire logic ov_fault_flag_r,
  input wire logic ov_warn_flag_r,
  input wire ovp_pkg::ovp_state_t ovp_state_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ========================================================================
  // Shadow copies of the limits and action, kept from the write traffic
  logic [15:0] lim_r, warn_r;
  logic [7:0] act_r;
  logic known, ov;
  assign known = reg_code inside {8'h36, 8'h37, 8'h39, 8'h40, 8'h41, 8'h42};
  assign ov = vout_meas > lim_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lim_r <= 16'hFFFF;
      warn_r <= 16'hFFFF;
      act_r <= 8'h80;
    end else if (reg_wr) begin
      if (reg_code == `CODE_OUTPUT_HIGH_FAULT_LIMIT) lim_r <= reg_wdata;
      if (reg_code == `CODE_OUTPUT_HIGH_WARN_LIMIT) warn_r <= reg_wdata;
      if (reg_code == `CODE_OUTPUT_HIGH_FAULT_ACTION) act_r <= reg_wdata[7:0];
    end
  end

  // ========================================================================
  // Assertions
  a_ack_known: assert property (
    (reg_wr || reg_rd) && known |=> reg_ack_r && !reg_nack_r)
    else $error("known code not acknowledged");
  a_nack_unknown: assert property (
    (reg_wr || reg_rd) && !known |=> reg_nack_r && !reg_ack_r)
    else $error("unknown code not refused");
  a_limit_readback: assert property (
    reg_rd && reg_code == `CODE_OUTPUT_HIGH_FAULT_LIMIT
    |=> reg_rdata_r == lim_r)
    else $error("fault limit read back wrong");
  a_action_readback: assert property (
    reg_rd && reg_code == `CODE_OUTPUT_HIGH_FAULT_ACTION
    |=> reg_rdata_r == {8'h00, act_r})
    else $error("action read back wrong");
  a_fault_flag_set: assert property (ov |=> ov_fault_flag_r)
    else $error("fault flag missed");
  a_warn_flag_set: assert property (
    vout_meas > warn_r |=> ov_warn_flag_r)
    else $error("warning flag missed");
  a_ignore_keeps_run: assert property (
    ovp_state_r == ovp_pkg::ST_RUN && act_r[7:6] == `RESP_IGNORE
    |=> ovp_state_r == ovp_pkg::ST_RUN)
    else $error("ignore mode left run");
  a_disable_at_once: assert property (
    ovp_state_r == ovp_pkg::ST_RUN && act_r[7:6] == `RESP_DISABLE && ov
    && !clear_faults |=> ovp_state_r inside {ovp_pkg::ST_RETRY_WAIT,
    ovp_pkg::ST_LATCHED} ##1 !output_enable_r)
    else $error("disable response late");
  a_hold_enter: assert property (
    ovp_state_r == ovp_pkg::ST_RUN && act_r[7:6] == `RESP_HOLD_OFF && ov
    |=> ovp_state_r == ovp_pkg::ST_HOLD_OFF ##1 !output_enable_r)
    else $error("hold-off not entered");
  a_hold_release: assert property (
    ovp_state_r == ovp_pkg::ST_HOLD_OFF && !ov
    |=> ovp_state_r == ovp_pkg::ST_RUN)
    else $error("hold-off not released");
  a_latched_stays: assert property (
    ovp_state_r == ovp_pkg::ST_LATCHED && !clear_faults
    |=> $stable(ovp_state_r) && !output_enable_r)
    else $error("latched shutdown left early");
endmodule : ovp_checker

bind output_overvoltage_protect_cfg ovp_checker ovp_checker_i (
  .clk(clk), .rst_n(rst_n), .reg_code(reg_code), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .vout_meas(vout_meas),
  .clear_faults(clear_faults), .reg_rdata_r(reg_rdata_r),
  .reg_ack_r(reg_ack_r), .reg_nack_r(reg_nack_r),
  .output_enable_r(output_enable_r), .ov_fault_flag_r(ov_fault_flag_r),
  .ov_warn_flag_r(ov_warn_flag_r), .ovp_state_r(ovp_state_r));

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the OV block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_code = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, run_request = 1'b0;
  logic clear_faults = 1'b0, sync_on = 1'b0;
  logic [15:0] reg_wdata = 16'h0000, vin_meas = 16'h0000;
  logic [15:0] vout_meas = 16'h0000, iout_raw = 16'h0000;
  logic sync_edge, delay_unit_tick, reg_ack_r, reg_nack_r, ov_warn_flag_r;
  logic conv_running_r, output_enable_r, phase_start_r, ov_fault_flag_r;
  logic [15:0] reg_rdata_r;
  logic [3:0] group_id_r;
  ovp_pkg::fixed_t iout_reading_r;
  ovp_pkg::ovp_state_t ovp_state_r;
  int bad_count = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  output_overvoltage_protect_cfg output_overvoltage_protect_cfg_i (
    .clk(clk), .rst_n(rst_n), .reg_code(reg_code), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_ack_r(reg_ack_r), .reg_nack_r(reg_nack_r),
    .run_request(run_request), .vin_meas(vin_meas), .vout_meas(vout_meas),
    .iout_raw(iout_raw), .delay_unit_tick(delay_unit_tick),
    .clear_faults(clear_faults), .sync_edge(sync_edge),
    .conv_running_r(conv_running_r), .output_enable_r(output_enable_r),
    .ov_fault_flag_r(ov_fault_flag_r), .ov_warn_flag_r(ov_warn_flag_r),
    .iout_reading_r(iout_reading_r), .phase_start_r(phase_start_r),
    .group_id_r(group_id_r), .ovp_state_r(ovp_state_r));

  far_side_model far_side_model_i (.clk(clk), .sync_on(sync_on),
    .sync_edge(sync_edge), .delay_unit_tick(delay_unit_tick));

  // ========================================================================
  // Tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // One strobe, answer looked at in the single cycle it stands
  task automatic access(input logic wr, input logic [7:0] c,
                        input logic [15:0] d, input logic ok);
    reg_code = c;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    step(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chk({reg_ack_r, reg_nack_r}, {ok, !ok});
    step(1);
  endtask : access

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    access(1'b1, c, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    access(1'b0, c, 16'h0000, 1'b1);
    chk(reg_rdata_r, e);
  endtask : rd

  task automatic clr;
    clear_faults = 1'b1;
    step(1);
    clear_faults = 1'b0;
    step(1);
  endtask : clr

  task automatic wait_state(input ovp_pkg::ovp_state_t s);
    int n;
    n = 0;
    while (ovp_state_r !== s && n < 400) begin
      step(1);
      n++;
    end
    chk(ovp_state_r, s);
  endtask : wait_state

  task automatic gap(output int d);
    d = 0;
    while (sync_edge !== 1'b1) step(1);
    while (phase_start_r !== 1'b1 && d < 40) begin
      step(1);
      d++;
    end
  endtask : gap

  // ========================================================================
  // Tests
  logic [7:0] cd [6] = '{8'h36, 8'h37, 8'h39, 8'h40, 8'h41, 8'h42};
  logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
                          16'h0080, 16'hFFFF};
  logic [15:0] mk [6] = '{16'hFFFF, 16'h0FFF, 16'hFFFF, 16'hFFFF,
                          16'h00FF, 16'hFFFF};

  initial begin
    int runs;
    int d;
    logic seen_latch;
    runs = 0;
    seen_latch = 1'b0;
    step(4);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rd(cd[i], rv[i]);
    for (int i = 0; i < 6; i++) begin
      wr(cd[i], 16'hFFFF ^ 16'(i));
      rd(cd[i], (16'hFFFF ^ 16'(i)) & mk[i]);
    end
    chk(group_id_r, 4'hF);
    access(1'b0, 8'h38, 16'h0000, 1'b0);
    chk(reg_rdata_r, 16'h0000);
    // Trim of one half added to a raw reading of five
    wr(8'h39, 16'hF801);
    iout_raw = 16'h0005;
    step(2);
    chk(iout_reading_r, 48'h0000_0005_8000);
    wr(8'h36, 16'h000A);
    vin_meas = 16'h000C;
    run_request = 1'b1;
    step(2);
    chk(conv_running_r, 1'b1);
    vin_meas = 16'h000A;
    step(2);
    chk(conv_running_r, 1'b0);
    vin_meas = 16'h000C;
    step(2);
    wr(8'h40, 16'h6000);
    wr(8'h42, 16'h5800);
    vout_meas = 16'h5C00;
    step(2);
    chk({ov_fault_flag_r, ov_warn_flag_r, ovp_state_r}, 5'b01000);
    vout_meas = 16'h5000;
    clr();
    wr(8'h41, 16'h0000);
    vout_meas = 16'h7000;
    step(3);
    chk({ov_fault_flag_r, ovp_state_r, output_enable_r}, 5'b10001);
    vout_meas = 16'h5000;
    clr();
    wr(8'h41, 16'h00C0);
    vout_meas = 16'h7000;
    step(3);
    chk({ovp_state_r,output_enable_r},{ovp_pkg::ST_HOLD_OFF,1'b0});
    vout_meas = 16'h5000;
    step(3);
    chk({ovp_state_r, output_enable_r}, {ovp_pkg::ST_RUN, 1'b1});
    wr(8'h41, 16'h0080);
    vout_meas = 16'h7000;
    step(1);
    vout_meas = 16'h5000;
    step(5);
    chk({ovp_state_r,output_enable_r},{ovp_pkg::ST_LATCHED,1'b0});
    clr();
    step(1);
    chk({ovp_state_r, output_enable_r}, {ovp_pkg::ST_RUN, 1'b1});
    // One retry, four units apart, then the budget is spent
    wr(8'h41, 16'h008A);
    vout_meas = 16'h7000;
    step(1);
    vout_meas = 16'h5000;
    step(12);
    chk(ovp_state_r, ovp_pkg::ST_RETRY_WAIT);
    wait_state(ovp_pkg::ST_RUN);
    vout_meas = 16'h7000;
    step(1);
    vout_meas = 16'h5000;
    step(3);
    chk(ovp_state_r, ovp_pkg::ST_LATCHED);
    clr();
    wr(8'h41, 16'h00B8);
    vout_meas = 16'h7000;
    repeat (300) begin
      step(1);
      if (ovp_state_r === ovp_pkg::ST_RUN) runs++;
      if (ovp_state_r === ovp_pkg::ST_LATCHED) seen_latch = 1'b1;
    end
    chk({runs >= 8, seen_latch}, 2'b10);
    vout_meas = 16'h5000;
    clr();
    wait_state(ovp_pkg::ST_RUN);
    wr(8'h41, 16'h0041);
    vout_meas = 16'h7000;
    step(2);
    chk(ovp_state_r, ovp_pkg::ST_CONT_DELAY);
    chk(output_enable_r, 1'b1);
    wait_state(ovp_pkg::ST_LATCHED);
    vout_meas = 16'h5000;
    clr();
    wait_state(ovp_pkg::ST_RUN);
    // Two rails: second unit starts half a sync period late
    wr(8'h37, 16'h0321);
    sync_on = 1'b1;
    step(60);
    gap(d);
    chk(d >= 9 && d <= 13, 1'b1);
    wr(8'h37, 16'h0320);
    step(45);
    gap(d);
    chk(d <= 4, 1'b1);
    finish_test();
  end

  initial begin
    repeat (10000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule : tb

`default_nettype wire
